// ==== tmr8_pkg.sv ====
package tmr8_pkg;

    localparam int unsigned TMR8_ADDR_W = 3;
    localparam int unsigned TMR8_DATA_W = 8;
    localparam int unsigned TMR8_PSC_W  = 10;
    localparam int unsigned TMR8_CS_W   = 3;

    // Register map
    localparam logic [TMR8_ADDR_W-1:0] TMR8_ADDR_CTRL    = 3'h0;
    localparam logic [TMR8_ADDR_W-1:0] TMR8_ADDR_COUNT   = 3'h1;
    localparam logic [TMR8_ADDR_W-1:0] TMR8_ADDR_COMPARE = 3'h2;
    localparam logic [TMR8_ADDR_W-1:0] TMR8_ADDR_FLAGS   = 3'h3;
    localparam logic [TMR8_ADDR_W-1:0] TMR8_ADDR_DIR     = 3'h4;

    // Control register fields
    localparam int unsigned TMR8_CTRL_WGM_LSB   = 0;
    localparam int unsigned TMR8_CTRL_COM_LSB   = 2;
    localparam int unsigned TMR8_CTRL_CS_LSB    = 4;
    localparam int unsigned TMR8_CTRL_FORCE_BIT = 7;

    // Flag register and direction register fields
    localparam int unsigned TMR8_FLAG_OVF_BIT   = 0;
    localparam int unsigned TMR8_FLAG_MATCH_BIT = 1;
    localparam int unsigned TMR8_DIR_OUT_BIT    = 0;

    typedef enum logic [1:0] {
        TMR8_WGM_NORMAL = 2'b00,
        TMR8_WGM_PCPWM  = 2'b01,
        TMR8_WGM_CTC    = 2'b10,
        TMR8_WGM_FAST   = 2'b11
    } tmr8_wgm_t;

    typedef enum logic [1:0] {
        TMR8_COM_OFF    = 2'b00,
        TMR8_COM_TOGGLE = 2'b01,
        TMR8_COM_CLEAR  = 2'b10,
        TMR8_COM_SET    = 2'b11
    } tmr8_com_t;

    localparam logic [TMR8_DATA_W-1:0] TMR8_CNT_MAX    = 8'hff;
    localparam logic [TMR8_DATA_W-1:0] TMR8_CNT_BOTTOM = 8'h00;
    localparam logic [TMR8_DATA_W-1:0] TMR8_CNT_ONE    = 8'h01;
    localparam logic [TMR8_DATA_W-1:0] TMR8_ZERO_BYTE  = 8'h00;

    // Prescaler masks: divide-by (mask+1); select 0 stops the timer
    localparam logic [TMR8_CS_W-1:0]  TMR8_CS_STOP = 3'h0;
    localparam logic [TMR8_PSC_W-1:0] TMR8_PSC_ONE = 10'h001;
    localparam logic [TMR8_PSC_W-1:0] TMR8_PSC_MASK [8] = '{
        10'h000, 10'h000, 10'h007, 10'h01f, 10'h03f, 10'h07f, 10'h0ff, 10'h3ff
    };

endpackage

// ==== tmr8_prescaler.sv ====
`timescale 1ns/1ps
module tmr8_prescaler
    import tmr8_pkg::*;
(
    input  wire logic                        i_mclk,
    input  wire logic                        i_rst_b,
    input  wire logic [tmr8_pkg::TMR8_CS_W-1:0] i_cs,
    output logic                             o_tick
);

    logic [TMR8_PSC_W-1:0] psc_ff;
    logic [TMR8_PSC_W-1:0] mask;

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            psc_ff <= '0;
        end
        else
        begin
            psc_ff <= psc_ff + TMR8_PSC_ONE;
        end
    end

    // Divide by 1, 8, 32, 64, 128, 256 or 1024
    assign mask   = TMR8_PSC_MASK[i_cs]; // RULE19
    assign o_tick = (i_cs != TMR8_CS_STOP) && ((psc_ff & mask) == mask); // RULE23

endmodule

// ==== tmr8_wave.sv ====
//Behaviour
//RULE1 - Output mode zero leaves compare output untouched on every match.
//RULE2 - New output mode applies from the first match after the write.
//RULE3 - Force strobe applies the output action at once in non-PWM modes.
//RULE4 - Counting depends on waveform mode only; output mode picks action.
//RULE5 - Mode 0 always increments, never clears on match, wraps 0xff to 0x00.
//RULE6 - Normal mode sets overflow flag as counter becomes zero.
//RULE7 - Normal mode accepts a counter write at any time.
//RULE8 - Mode 2 clears counter when it equals the compare value.
//RULE9 - Clear-on-match compare is unbuffered; a missed match runs to 0xff.
//RULE10 - Clear-on-match with output mode 1 toggles output each match.
//RULE11 - Clear-on-match sets match flag each time top is reached.
//RULE12 - Clear-on-match sets overflow flag going from 0xff to 0x00.
//RULE13 - Pin is driven only when its direction bit selects output.
//RULE14 - Mode 3 counts up to 0xff, then clears to bottom next tick.
//RULE15 - Fast PWM: mode 2 clears on match, sets at bottom; mode 3 opposite.
//RULE16 - Fast PWM sets overflow flag each time counter reaches 0xff.
//RULE17 - Fast PWM compare at bottom spikes; compare at 0xff gives constant.
//RULE18 - Fast PWM output mode 1 toggles on match; buffering stays.
//RULE19 - PWM period is 256 ticks; tick from selectable prescaler.
//RULE20 - Compare buffered in PWM, loaded at bottom; direct otherwise.
//RULE21 - Counter write blocks any match in the next timer tick.
//RULE22 - Forced compare touches only output, no flag, no counter change.
//RULE23 - Timer tick is a one-cycle enable qualifying all updates.
//
// Our own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module tmr8_wave
    import tmr8_pkg::*;
(
    input  wire logic                              i_mclk,
    input  wire logic                              i_rst_b,
    input  wire logic [tmr8_pkg::TMR8_ADDR_W-1:0] i_addr,
    input  wire logic [tmr8_pkg::TMR8_DATA_W-1:0] i_wdata,
    input  wire logic                              i_wr,
    input  wire logic                              i_rd,
    output logic      [tmr8_pkg::TMR8_DATA_W-1:0] o_rdata,
    output logic                                   o_compare_output,
    output logic                                   o_pin_oe,
    output logic                                   o_overflow_flag,
    output logic                                   o_compare_match_flag
);

    import tmr8_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations

    tmr8_wgm_t                 wgm_ff;
    tmr8_com_t                 com_ff;
    logic [TMR8_CS_W-1:0]      cs_ff;
    logic [TMR8_DATA_W-1:0]    cnt_ff;
    logic [TMR8_DATA_W-1:0]    ocr_buf_ff;
    logic [TMR8_DATA_W-1:0]    ocr_ff;
    logic                      block_ff;
    logic                      oc_ff;
    logic                      nxt_oc;
    logic                      ovf_ff;
    logic                      mf_ff;
    logic                      ddr_ff;
    logic                      pin_oe_ff;
    logic [TMR8_DATA_W-1:0]    rdata_ff;
    logic [TMR8_DATA_W-1:0]    nxt_rdata;

    logic                      tick;
    logic                      wr_ctrl;
    logic                      wr_count;
    logic                      wr_compare;
    logic                      wr_flags;
    logic                      wr_dir;
    logic                      is_pwm;
    logic                      is_fast;
    logic                      at_max;
    logic                      match_hit;
    logic                      force_go;
    tmr8_com_t                 wr_com;

    ////////////////////////////////////////////////////////////////////////////////
    // Prescaled timer tick

    tmr8_prescaler u_prescaler
    (
        .i_mclk  (i_mclk),
        .i_rst_b (i_rst_b),
        .i_cs    (cs_ff),
        .o_tick  (tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Decode

    assign wr_ctrl    = i_wr && (i_addr == TMR8_ADDR_CTRL);
    assign wr_count   = i_wr && (i_addr == TMR8_ADDR_COUNT);
    assign wr_compare = i_wr && (i_addr == TMR8_ADDR_COMPARE);
    assign wr_flags   = i_wr && (i_addr == TMR8_ADDR_FLAGS);
    assign wr_dir     = i_wr && (i_addr == TMR8_ADDR_DIR);

    assign wr_com   = tmr8_com_t'(i_wdata[TMR8_CTRL_COM_LSB +: 2]);
    assign is_pwm   = wgm_ff[0];
    assign is_fast  = (wgm_ff == TMR8_WGM_FAST);
    assign at_max   = (cnt_ff == TMR8_CNT_MAX);
    assign match_hit = (cnt_ff == ocr_ff) && !block_ff; // RULE21
    // Strobe acts with the output mode and waveform mode written with it
    assign force_go = wr_ctrl && i_wdata[TMR8_CTRL_FORCE_BIT]
                      && !i_wdata[TMR8_CTRL_WGM_LSB]; // RULE3

    ////////////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wgm_ff <= TMR8_WGM_NORMAL;
            com_ff <= TMR8_COM_OFF;
            cs_ff  <= TMR8_CS_STOP;
        end
        else if (wr_ctrl)
        begin
            wgm_ff <= tmr8_wgm_t'(i_wdata[TMR8_CTRL_WGM_LSB +: 2]);
            com_ff <= wr_com;
            cs_ff  <= i_wdata[TMR8_CTRL_CS_LSB +: TMR8_CS_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counter

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_ff <= TMR8_CNT_BOTTOM;
        end
        else if (wr_count)
        begin
            cnt_ff <= i_wdata; // RULE7
        end
        else if (tick) // RULE23
        begin
            if ((wgm_ff == TMR8_WGM_CTC) && match_hit)
            begin
                cnt_ff <= TMR8_CNT_BOTTOM; // RULE8
            end
            else
            begin
                // Wraps 0xff to 0x00 in every mode, giving 256-tick periods in modes 0, 1 and 3
                cnt_ff <= cnt_ff + TMR8_CNT_ONE; // RULE4 RULE5 RULE9 RULE14 RULE19
            end
        end
    end

    // Match block lasts until the next timer tick
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            block_ff <= 1'b0;
        end
        else if (wr_count)
        begin
            block_ff <= 1'b1; // RULE21
        end
        else if (tick)
        begin
            block_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Compare value, buffered in PWM modes

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ocr_buf_ff <= TMR8_ZERO_BYTE;
        end
        else if (wr_compare)
        begin
            ocr_buf_ff <= i_wdata;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ocr_ff <= TMR8_ZERO_BYTE;
        end
        else if (wr_compare && !is_pwm)
        begin
            ocr_ff <= i_wdata; // RULE9 RULE20
        end
        else if (is_pwm && tick && at_max)
        begin
            ocr_ff <= ocr_buf_ff; // RULE18 RULE20
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Waveform generator

    function automatic logic match_action(input logic oc, input tmr8_com_t com);
        logic res;
        res = oc;
        unique case (com)
            TMR8_COM_OFF:    res = oc; // RULE1
            TMR8_COM_TOGGLE: res = ~oc; // RULE10 RULE18
            TMR8_COM_CLEAR:  res = 1'b0;
            TMR8_COM_SET:    res = 1'b1;
        endcase
        return res;
    endfunction

    always_comb
    begin
        nxt_oc = oc_ff;
        if (tick && is_fast)
        begin
            if (match_hit)
            begin
                nxt_oc = match_action(oc_ff, com_ff); // RULE15 RULE18
            end
            // Bottom action follows the match, so compare 0xff gives a steady level
            if (at_max && (com_ff == TMR8_COM_CLEAR))
            begin
                nxt_oc = 1'b1; // RULE15 RULE17
            end
            else if (at_max && (com_ff == TMR8_COM_SET))
            begin
                nxt_oc = 1'b0; // RULE15 RULE17
            end
        end
        else if (tick && !is_pwm && match_hit)
        begin
            // Output mode sampled at the match itself
            nxt_oc = match_action(oc_ff, com_ff); // RULE2 RULE4
        end
        if (force_go)
        begin
            nxt_oc = match_action(oc_ff, wr_com); // RULE3 RULE22
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            oc_ff <= 1'b0;
        end
        else
        begin
            oc_ff <= nxt_oc;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags: set wins over a write-one clear

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ovf_ff <= 1'b0;
        end
        else if (tick && at_max && !wr_count)
        begin
            ovf_ff <= 1'b1; // RULE6 RULE12 RULE16
        end
        else if (wr_flags && i_wdata[TMR8_FLAG_OVF_BIT])
        begin
            ovf_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            mf_ff <= 1'b0;
        end
        else if (tick && match_hit)
        begin
            mf_ff <= 1'b1; // RULE11
        end
        else if (wr_flags && i_wdata[TMR8_FLAG_MATCH_BIT])
        begin
            mf_ff <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin direction

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            ddr_ff <= 1'b0;
        end
        else if (wr_dir)
        begin
            ddr_ff <= i_wdata[TMR8_DIR_OUT_BIT];
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pin_oe_ff <= 1'b0;
        end
        else
        begin
            pin_oe_ff <= ddr_ff && (com_ff != TMR8_COM_OFF); // RULE13
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port

    always_comb
    begin
        nxt_rdata = TMR8_ZERO_BYTE;
        if (i_rd)
        begin
            unique case (i_addr)
                TMR8_ADDR_CTRL:    nxt_rdata = {1'b0, cs_ff, com_ff, wgm_ff};
                TMR8_ADDR_COUNT:   nxt_rdata = cnt_ff;
                TMR8_ADDR_COMPARE: nxt_rdata = ocr_buf_ff;
                TMR8_ADDR_FLAGS:   nxt_rdata = {6'h00, mf_ff, ovf_ff};
                TMR8_ADDR_DIR:     nxt_rdata = {7'h00, ddr_ff};
                default:           nxt_rdata = TMR8_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            rdata_ff <= TMR8_ZERO_BYTE;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign o_rdata              = rdata_ff;
    assign o_compare_output     = oc_ff;
    assign o_pin_oe             = pin_oe_ff;
    assign o_overflow_flag      = ovf_ff;
    assign o_compare_match_flag = mf_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_b);

    a_com_off_hold: assert property ( // RULE1
        (tick && (com_ff == TMR8_COM_OFF) && !force_go) |=> $stable(oc_ff))
        else $error("output moved with output mode zero");
    a_force_set_now: assert property ( // RULE3
        (force_go && (wr_com == TMR8_COM_SET)) |=> oc_ff)
        else $error("forced set did not drive output high");
    a_force_quiet: assert property ( // RULE22
        (force_go && !tick && !mf_ff) |=> (!mf_ff && $stable(cnt_ff)))
        else $error("forced compare touched flag or counter");
    a_normal_step: assert property ( // RULE5
        (tick && (wgm_ff == TMR8_WGM_NORMAL) && !wr_count)
        |=> (cnt_ff == $past(cnt_ff) + TMR8_CNT_ONE))
        else $error("normal mode counter did not increment");
    a_ovf_at_wrap: assert property ( // RULE6
        (tick && at_max && !wr_count) |=> (ovf_ff && (cnt_ff == TMR8_CNT_BOTTOM)))
        else $error("overflow flag not set on wrap");
    a_ctc_clear: assert property ( // RULE8
        (tick && (wgm_ff == TMR8_WGM_CTC) && match_hit && !wr_count)
        |=> (cnt_ff == TMR8_CNT_BOTTOM) && mf_ff)
        else $error("clear-on-match did not clear and flag");
    a_ctc_toggle: assert property ( // RULE10
        (tick && (wgm_ff == TMR8_WGM_CTC) && match_hit && (com_ff == TMR8_COM_TOGGLE)
         && !force_go) |=> (oc_ff != $past(oc_ff)))
        else $error("toggle mode did not toggle on match");
    a_write_blocks: assert property ( // RULE21
        (wr_count && !mf_ff && !(tick && match_hit)) ##1 (tick && !wr_flags) |=> !mf_ff)
        else $error("match not blocked after counter write");
    a_fast_bottom: assert property ( // RULE15
        (tick && is_fast && at_max && (com_ff == TMR8_COM_CLEAR) && !force_go) |=> oc_ff)
        else $error("fast pwm output not set at bottom");
    a_pwm_buffer: assert property ( // RULE20
        (is_pwm && wr_compare && !(tick && at_max)) |=> $stable(ocr_ff))
        else $error("pwm compare loaded outside bottom");
    a_pin_gate: assert property ( // RULE13
        !ddr_ff |=> !pin_oe_ff)
        else $error("pin enabled without output direction");

    c_ctc_toggle: cover property (
        tick && (wgm_ff == TMR8_WGM_CTC) && match_hit && (com_ff == TMR8_COM_TOGGLE));
    c_fast_wrap: cover property (tick && is_fast && at_max);
    c_force: cover property (force_go);
    c_blocked: cover property (tick && block_ff && (cnt_ff == ocr_ff));

endmodule

// ==== tmr8_load.sv ====
`timescale 1ns/1ps
module tmr8_load
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_b,
    input  wire logic        i_pin_oe,
    input  wire logic        i_compare_output,
    output logic             o_pin_level,
    output logic             o_rise,
    output logic [15:0]      o_period
);
    logic        level_ff;
    logic [15:0] gap_ff;

    // Pull-down holds the pin low while undriven
    assign o_pin_level = i_pin_oe ? i_compare_output : 1'b0;
    assign o_rise      = o_pin_level && !level_ff;

    ////////////////////////////////////////////////////////////////////////////////
    // Rise-to-rise distance seen by the load
    always_ff @(posedge i_mclk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            level_ff <= 1'b0;
            gap_ff   <= 16'h0000;
            o_period <= 16'h0000;
        end
        else
        begin
            level_ff <= o_pin_level;
            gap_ff   <= o_rise ? 16'h0001 : gap_ff + 16'h0001;
            if (o_rise)
                o_period <= gap_ff;
        end
    end
endmodule

// ==== tmr8_wave_test.sv ====
`timescale 1ns/1ps
module tmr8_wave_test;
    import tmr8_pkg::*;

    logic                   mclk;
    logic                   rst_b;
    logic [TMR8_ADDR_W-1:0] addr;
    logic [TMR8_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
    logic [TMR8_DATA_W-1:0] rdata;
    logic                   cmp_out;
    logic                   pin_oe;
    logic                   ovf;
    logic                   mf;
    logic                   pin_level;
    logic                   pin_rise;
    logic [15:0]            period;
    logic [7:0]             lfsr_q;
    int                     err_total;
    int                     samples_checked;
    int m_cnt, m_buf, m_act, m_wgm, m_com, m_cs, m_dir, m_ovf, m_mf, m_oc, m_oe, m_rd, m_blk;
    int                     r;
    int                     m_psc;
    int                     div_tab[8] = '{1, 1, 8, 32, 64, 128, 256, 1024};
    bit                     tick;
    bit                     hit;
    bit                     wc;

    tmr8_wave i_dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_compare_output(cmp_out),
        .o_pin_oe(pin_oe), .o_overflow_flag(ovf), .o_compare_match_flag(mf));

    tmr8_load i_load (.i_mclk(mclk), .i_rst_b(rst_b), .i_pin_oe(pin_oe),
        .i_compare_output(cmp_out), .o_pin_level(pin_level), .o_rise(pin_rise),
        .o_period(period));

    initial
    begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Reference model, one timer tick per clock when select is 1
    function automatic int act_fn(int c, int o);
        case (c)
            1: return o ^ 1;
            2: return 0;
            3: return 1;
            default: return o;
        endcase
    endfunction

    function automatic logic [7:0] lfsr_next(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    always @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            {m_cnt, m_buf, m_act, m_wgm, m_com, m_cs, m_dir} = '0;
            {m_ovf, m_mf, m_oc, m_oe, m_rd, m_blk, m_psc} = '0;
        end
        else
        begin
            tick = (m_cs != 0) && (m_psc % div_tab[m_cs] == div_tab[m_cs] - 1);
            m_psc = (m_psc + 1) % 1024;
            hit  = tick && !m_blk && (m_cnt == m_act);
            wc   = wr && (addr == TMR8_ADDR_COUNT);
            m_oe = m_dir && (m_com != 0);
            m_rd = 0;
            if (rd)
                case (addr)
                    TMR8_ADDR_CTRL:    m_rd = m_cs * 16 + m_com * 4 + m_wgm;
                    TMR8_ADDR_COUNT:   m_rd = m_cnt;
                    TMR8_ADDR_COMPARE: m_rd = m_buf;
                    TMR8_ADDR_FLAGS:   m_rd = m_mf * 2 + m_ovf;
                    TMR8_ADDR_DIR:     m_rd = m_dir;
                    default:           m_rd = 0;
                endcase
            if (hit)
                m_oc = act_fn(m_com, m_oc);
            if (tick && m_wgm == 3 && m_cnt == 255 && m_com >= 2)
                m_oc = (m_com == 2);
            if (wr && addr == TMR8_ADDR_CTRL && wdata[7] && !wdata[0])
                m_oc = act_fn(int'(wdata[3:2]), m_oc);
            if (wr && addr == TMR8_ADDR_FLAGS)
            begin
                m_ovf = m_ovf & !wdata[0];
                m_mf  = m_mf & !wdata[1];
            end
            if (tick && m_cnt == 255 && !wc)
                m_ovf = 1;
            if (hit)
                m_mf = 1;
            if (tick && m_wgm % 2 == 1 && m_cnt == 255)
                m_act = m_buf;
            if (wc)
                m_cnt = wdata;
            else if (tick)
                m_cnt = (m_wgm == 2 && hit) ? 0 : (m_cnt + 1) % 256;
            if (wc)
                m_blk = 1;
            else if (tick)
                m_blk = 0;
            if (wr && addr == TMR8_ADDR_COMPARE)
            begin
                m_buf = wdata;
                if (m_wgm % 2 == 0)
                    m_act = wdata;
            end
            if (wr && addr == TMR8_ADDR_CTRL)
                {m_cs, m_com, m_wgm} = {int'(wdata[6:4]), int'(wdata[3:2]), int'(wdata[1:0])};
            if (wr && addr == TMR8_ADDR_DIR)
                m_dir = wdata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks and bus tasks
    task automatic check(string n, int e, logic [7:0] g);
        samples_checked++;
        if (g !== e[7:0])
        begin
            err_total++;
            $display("unexpected %s expected %0h seen %0h", n, e, g);
        end
    endtask

    always @(negedge mclk)
    begin
        if (rst_b)
        begin
            check("rdata", m_rd, rdata);
            check("compare_output", m_oc, cmp_out);
            check("pin_oe", m_oe, pin_oe);
            check("overflow_flag", m_ovf, ovf);
            check("compare_match_flag", m_mf, mf);
        end
    end

    task automatic wr_reg(logic [TMR8_ADDR_W-1:0] a, logic [7:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask

    task automatic rd_reg(logic [TMR8_ADDR_W-1:0] a);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_rise();
        int n;
        for (n = 0; n < 1200 && !pin_rise; n++)
            @(negedge mclk);
        if (!pin_rise)
        begin
            err_total++;
            $display("unexpected pin_rise expected 1 seen 0");
            tally_and_finish();
        end
        @(negedge mclk);
    endtask

    task automatic rnd();
        lfsr_q = lfsr_next(lfsr_q);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Scenarios
    initial
    begin
        {rst_b, addr, wdata, wr, rd} = '0;
        lfsr_q = 8'h20;
        err_total = 0;
        samples_checked = 0;
        repeat (5) @(posedge mclk);
        rst_b <= 1'b1;
        for (r = 0; r < 8; r++)
            rd_reg(r[2:0]);
        $display("test reset done");
        rnd();
        wr_reg(TMR8_ADDR_COUNT, 8'hfc);
        wr_reg(TMR8_ADDR_COMPARE, lfsr_q);
        wr_reg(TMR8_ADDR_CTRL, 8'h1c);
        repeat (10) @(posedge mclk);
        rnd();
        wr_reg(TMR8_ADDR_COUNT, lfsr_q);
        repeat (600) @(posedge mclk);
        wr_reg(TMR8_ADDR_CTRL, 8'h2c);
        repeat (100) @(posedge mclk);
        rd_reg(TMR8_ADDR_COUNT);
        wr_reg(TMR8_ADDR_CTRL, 8'h0c);
        rd_reg(TMR8_ADDR_COUNT);
        rd_reg(TMR8_ADDR_FLAGS);
        $display("test normal done");
        wr_reg(TMR8_ADDR_FLAGS, 8'h03);
        for (r = 0; r < 8; r++)
            wr_reg(TMR8_ADDR_CTRL, 8'h80 | (r[7:0] << 1));
        rd_reg(TMR8_ADDR_CTRL);
        rd_reg(TMR8_ADDR_COUNT);
        samples_checked++;
        if (mf !== 1'b0)
        begin
            err_total++;
            $display("unexpected force_flag expected 0 seen %0h", mf);
        end
        $display("test force done");
        wr_reg(TMR8_ADDR_DIR, 8'h01);
        wr_reg(TMR8_ADDR_COMPARE, (lfsr_q & 8'h0f) | 8'h01);
        wr_reg(TMR8_ADDR_CTRL, 8'h16);
        repeat (80) @(posedge mclk);
        wr_reg(TMR8_ADDR_CTRL, 8'h1a);
        repeat (40) @(posedge mclk);
        wr_reg(TMR8_ADDR_COMPARE, 8'h01);
        repeat (300) @(posedge mclk);
        $display("test clear_on_match done");
        wr_reg(TMR8_ADDR_CTRL, 8'h02);
        wr_reg(TMR8_ADDR_FLAGS, 8'h03);
        wr_reg(TMR8_ADDR_COUNT, 8'h05);
        wr_reg(TMR8_ADDR_COMPARE, 8'h05);
        wr_reg(TMR8_ADDR_CTRL, 8'h12);
        repeat (3) @(posedge mclk);
        @(negedge mclk);
        samples_checked++;
        if (mf !== 1'b0)
        begin
            err_total++;
            $display("unexpected blocked_match expected 0 seen %0h", mf);
        end
        $display("test write_block done");
        for (r = 0; r < 9; r++)
        begin
            rnd();
            wr_reg(TMR8_ADDR_COMPARE, r % 3 == 0 ? 8'h00 : r % 3 == 1 ? 8'hff
                : (lfsr_q & 8'h7f) | 8'h10);
            wr_reg(TMR8_ADDR_CTRL, 8'h13 | (((r / 3 + 1) % 3 + 1) << 2));
            repeat (1100) @(posedge mclk);
            if (r % 3 == 2)
            begin
                wait_rise();
                wait_rise();
                samples_checked++;
                if (period !== (r / 3 == 2 ? 16'h0200 : 16'h0100))
                begin
                    err_total++;
                    $display("unexpected period expected %0d seen %0d",
                        (r / 3 == 2 ? 512 : 256), period);
                end
            end
            wr_reg(TMR8_ADDR_CTRL, 8'h80 | ((r / 3 + 2) << 2) | 8'h13);
        end
        wr_reg(TMR8_ADDR_CTRL, 8'h1b);
        wr_reg(TMR8_ADDR_DIR, 8'h00);
        repeat (300) @(posedge mclk);
        @(negedge mclk);
        samples_checked++;
        if (pin_level !== 1'b0)
        begin
            err_total++;
            $display("unexpected pin_level expected 0 seen %0h", pin_level);
        end
        $display("test fast_pwm done");
        tally_and_finish();
    end
endmodule
